// ---- core/sfd_defs.vh ----
// Constants for the sequential error-correcting decoder.
`ifndef SFD_DEFS_VH
`define SFD_DEFS_VH
// ----------------------------------------
// Widths and depths
// ----------------------------------------
`define SFD_SOFT_W      2
`define SFD_IRAM_AW     6
`define SFD_IRAM_DEPTH  64
`define SFD_ORAM_AW     4
`define SFD_ORAM_DEPTH  16
`define SFD_SR_W        8
`define SFD_MET_W       12
// ----------------------------------------
// Code taps for the parity generator
// ----------------------------------------
`define SFD_TAPS        8'hb5
// ----------------------------------------
// Branch and path metric values
// ----------------------------------------
`define SFD_MET_GOOD    12'h002
`define SFD_MET_BAD     12'h009
`define SFD_MET_INIT    12'h100
// ----------------------------------------
// Timing, thresholds and windows
// ----------------------------------------
`define SFD_BUDGET_CYC  8'h10
`define SFD_LOCK_THR    16'h0010
`define SFD_WIN_BITS    16'h0400
`define SFD_OUT_DIV     8'h20
`endif

// ---- core/sfd_skid_buf.v ----
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sfd_skid_buf (
  input  wire       i_sys_clk,  // System clock.
  input  wire       i_srst,     // Synchronous reset, active high.
  input  wire       i_valid,    // Write side valid.
  input  wire [1:0] i_data,     // Write side data.
  output wire       o_ready,    // Write side ready.
  output wire       o_valid,    // Read side valid.
  output wire [1:0] o_data,     // Read side data.
  input  wire       i_ready     // Read side ready.
);
  reg  [1:0] mem_q [0:1];
  reg        wp_q;
  reg        rp_q;
  reg  [1:0] cnt_q;
  wire       wr = i_valid && (cnt_q != 2'h2);
  wire       rd = (cnt_q != 2'h0) && i_ready;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rp_q];

  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (wr) begin
        mem_q[wp_q] <= i_data;
        wp_q        <= ~wp_q;
      end
      if (rd)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, wr} - {1'b0, rd};
    end
  end
endmodule

// ---- core/sfd_decoder.v ----
// Sequential error-correcting decoder: input store, tree search, output retiming.
`timescale 1ns/1ps
`include "sfd_defs.vh"
module sfd_decoder (
  input  wire       i_sys_clk,    // 25 MHz system clock.
  input  wire       i_srst,       // Synchronous reset, active high.
  input  wire       i_sym_valid,  // Soft symbol present.
  input  wire [1:0] i_sym_i,      // I soft value, sign in bit 1.
  input  wire [1:0] i_sym_q,      // Q soft value, sign in bit 1.
  output wire       o_sym_ready,  // Symbol accepted when high with valid.
  input  wire [1:0] i_amb_rot,    // Phase rotation in quarter turns.
  output wire       o_bit_valid,  // Corrected bit present.
  output wire       o_bit_data,   // Corrected bit.
  input  wire       i_bit_ready,  // Receiver takes the bit.
  output reg        o_data_clk,   // Constant-rate data clock.
  output reg        o_data_out,   // Retimed data bit.
  output reg        o_lock,       // Lock detect.
  output reg [15:0] o_raw_err     // Raw error count of last window.
);
  // ----------------------------------------
  // Search engine states
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FWD  = 2'h1;
  localparam [1:0] ST_BACK = 2'h2;
  localparam [1:0] ST_EMIT = 2'h3;

  // ----------------------------------------
  // Input RAM
  // ----------------------------------------
  reg  [3:0] iram_q [0:`SFD_IRAM_DEPTH-1];
  reg  [5:0] wr_ptr_q;
  reg  [5:0] rd_ptr_q;
  reg  [5:0] base_q;
  reg  [1:0] st_q;
  reg  [1:0] st_d;
  reg  [7:0] budget_q;
  reg  [3:0] oram_q [0:`SFD_ORAM_DEPTH-1];
  wire [6:0] fill = {1'b0, wr_ptr_q} - {1'b0, base_q};
  wire       ram_full = (wr_ptr_q + 6'h01) == base_q;

  assign o_sym_ready = !ram_full;

  always @(posedge i_sys_clk) begin
    if (!i_srst && i_sym_valid && !ram_full)
      iram_q[wr_ptr_q] <= {i_sym_i, i_sym_q};
  end

  // ----------------------------------------
  // Ambiguity correction and hard decision
  // ----------------------------------------
  wire [3:0] raw_sym = iram_q[rd_ptr_q];
  reg  [1:0] ci;
  reg  [1:0] cq;
  always @* begin
    case (i_amb_rot)
      2'h1:    begin ci = ~raw_sym[1:0]; cq = raw_sym[3:2];  end
      2'h2:    begin ci = ~raw_sym[3:2]; cq = ~raw_sym[1:0]; end
      2'h3:    begin ci = raw_sym[1:0];  cq = ~raw_sym[3:2]; end
      default: begin ci = raw_sym[3:2];  cq = raw_sym[1:0];  end
    endcase
  end
  // A weak I that disagrees with a confident Q takes Q's sign; Q always keeps its own sign.
  wire weak_i = ci[1] ^ ci[0];
  wire weak_q = cq[1] ^ cq[0];
  wire hard_i = (weak_i && !weak_q && (ci[1] != cq[1])) ? cq[1] : ci[1];
  wire hard_q = cq[1];

  // ----------------------------------------
  // Syndrome registers and parity generator
  // ----------------------------------------
  reg  [7:0] sr_q;
  reg  [7:0] sr_save_q;
  reg        alt_q;
  wire       cand   = hard_i ^ alt_q;
  wire [7:0] sr_nxt = {sr_q[6:0], cand};
  wire       syn_err = (^(sr_nxt & `SFD_TAPS)) ^ hard_q;
  wire [11:0] bmet = syn_err ? `SFD_MET_BAD : `SFD_MET_GOOD;

  // ----------------------------------------
  // Tree search engine
  // ----------------------------------------
  reg  [11:0] pmet_q;
  reg  [11:0] pmet_save_q;
  reg         save_ok_q;
  reg  [5:0]  save_ptr_q;
  reg  [3:0]  ow_q;
  reg  [3:0]  or_q;
  reg         in_bit_q;
  reg         dec_bit_q;
  wire        oram_full = (ow_q + 4'h1) == or_q;
  wire        budget_out = (budget_q == `SFD_BUDGET_CYC);
  wire        hist_end = (rd_ptr_q == base_q) || !save_ok_q;
  wire        have_sym = rd_ptr_q != wr_ptr_q;
  // A good branch adds credit; a bad one costs more than it earns.
  wire [11:0] pmet_new = syn_err ? (pmet_q - bmet) : (pmet_q + bmet);

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (have_sym && !oram_full) st_d = ST_FWD;
      ST_FWD:  st_d = syn_err ? ST_BACK : ST_EMIT;
      ST_BACK: st_d = ST_EMIT;
      ST_EMIT: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // The engine steps at the full system clock while symbols arrive far
  // slower, so each symbol gets several trial branches.
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_q <= ST_IDLE;
      wr_ptr_q <= 6'h00;
      rd_ptr_q <= 6'h00;
      base_q <= 6'h00;
      sr_q <= 8'h00;
      sr_save_q <= 8'h00;
      alt_q <= 1'b0;
      pmet_q <= `SFD_MET_INIT;
      pmet_save_q <= `SFD_MET_INIT;
      save_ok_q <= 1'b0;
      save_ptr_q <= 6'h00;
      budget_q <= 8'h00;
      ow_q <= 4'h0;
      dec_bit_q <= 1'b0;
      in_bit_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (i_sym_valid && !ram_full)
        wr_ptr_q <= wr_ptr_q + 6'h01;
      case (st_q)
        ST_FWD: begin
          if (!syn_err) begin
            pmet_q <= pmet_new;
            sr_q <= sr_nxt;
            dec_bit_q <= cand;
            in_bit_q <= hard_i;
            pmet_save_q <= pmet_q;
            sr_save_q <= sr_q;
            save_ptr_q <= rd_ptr_q;
            save_ok_q <= 1'b1;
            rd_ptr_q <= rd_ptr_q + 6'h01;
            alt_q <= 1'b0;
          end
        end
        ST_BACK: begin
          budget_q <= budget_q + 8'h01;
          if (!alt_q && !budget_out) begin
            alt_q <= 1'b1;
          end else if (!hist_end && !budget_out) begin
            rd_ptr_q <= save_ptr_q;
            sr_q <= sr_save_q;
            pmet_q <= pmet_save_q;
            save_ok_q <= 1'b0;
            alt_q <= 1'b1;
          end else begin
            // Gave up: force the current candidate (hard decision XOR alt_q) through and move on.
            sr_q <= sr_nxt;
            dec_bit_q <= cand;
            in_bit_q <= hard_i;
            pmet_q <= pmet_new;
            rd_ptr_q <= rd_ptr_q + 6'h01;
            alt_q <= 1'b0;
          end
        end
        ST_EMIT: begin
          if (rd_ptr_q != base_q && fill != 7'h00) begin
            // The input bit travels with its own decision, since the read
            // pointer has already moved on to a symbol that may not exist yet.
            oram_q[ow_q] <= {in_bit_q, 2'h0, dec_bit_q};
            ow_q <= ow_q + 4'h1;
            base_q <= base_q + 6'h01;
            budget_q <= 8'h00;  // The budget is per delivered bit.
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Output RAM, buffer and retiming
  // ----------------------------------------
  wire       ob_ready;
  wire       oram_rd = (ow_q != or_q) && ob_ready;
  wire [3:0] oword = oram_q[or_q];
  wire       buf_valid;
  wire [1:0] buf_data;
  reg  [7:0] div_q;
  wire       tick = (div_q == `SFD_OUT_DIV);

  always @(posedge i_sys_clk) begin
    if (i_srst)
      or_q <= 4'h0;
    else if (oram_rd)
      or_q <= or_q + 4'h1;
  end

  sfd_skid_buf u_buf (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_valid   (ow_q != or_q),
    .i_data    ({oword[3], oword[0]}),
    .o_ready   (ob_ready),
    .o_valid   (buf_valid),
    .o_data    (buf_data),
    .i_ready   (i_bit_ready && tick)
  );

  assign o_bit_valid = buf_valid && tick;
  assign o_bit_data  = buf_data[0];

  // ----------------------------------------
  // Data clock, lock detect and raw error count
  // ----------------------------------------
  reg [15:0] win_q;
  reg [15:0] err_q;
  // Includes the bit being taken now, so lock and count agree at window end.
  wire [15:0] err_sum = err_q + {15'h0000, buf_data[1] ^ buf_data[0]};
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      div_q <= 8'h00;
      o_data_clk <= 1'b0;
      o_data_out <= 1'b0;
      win_q <= 16'h0000;
      err_q <= 16'h0000;
      o_raw_err <= 16'h0000;
      o_lock <= 1'b0;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      o_data_clk <= (div_q < (`SFD_OUT_DIV >> 1));
      if (tick && buf_valid && i_bit_ready) begin
        o_data_out <= buf_data[0];
        if (win_q == `SFD_WIN_BITS - 16'h0001) begin
          win_q <= 16'h0000;
          err_q <= 16'h0000;
          o_raw_err <= err_sum;
          o_lock <= (err_sum < `SFD_LOCK_THR);
        end else begin
          win_q <= win_q + 16'h0001;
          err_q <= err_sum;
        end
      end
    end
  end
endmodule

// ---- tb/sfd_decoder_asserts.sv ----
// Port-level checker for the sequential decoder, bound to its top module.
`timescale 1ns/1ps
module sfd_decoder_chk (
  input wire        i_sys_clk,    // System clock.
  input wire        i_srst,       // Synchronous reset.
  input wire        i_sym_valid,  // Symbol offered.
  input wire        o_sym_ready,  // Symbol accepted.
  input wire        o_bit_valid,  // Corrected bit present.
  input wire        o_bit_data,   // Corrected bit.
  input wire        i_bit_ready,  // Receiver takes the bit.
  input wire        o_data_clk,   // Constant-rate data clock.
  input wire        o_data_out,   // Retimed bit.
  input wire        o_lock,       // Lock detect.
  input wire [15:0] o_raw_err     // Raw error count.
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  wire take = o_bit_valid && i_bit_ready;
  // Counts taken bits so that window ends are visible at the ports.
  reg  [9:0] n_take_q;
  wire       win_end = take && (n_take_q == 10'h3ff);
  always @(posedge i_sys_clk) begin
    if (i_srst) n_take_q <= 10'h000;
    else if (take) n_take_q <= n_take_q + 10'h001;
  end
  sequence s_high;
    ##16 $fell(o_data_clk);
  endsequence
  sequence s_low;
    ##17 $rose(o_data_clk);
  endsequence
  AST_RST_IDLE: assert property (disable iff (1'b0) i_srst |=>
    !o_bit_valid && o_sym_ready && !o_lock && o_raw_err == 16'h0000) else $error("bad reset");
  AST_CLK_SHAPE: assert property ($rose(o_data_clk) |-> s_high ##0 s_low)
    else $error("data clock shape");
  AST_TAKE_OUT: assert property (take |=> o_data_out == $past(o_bit_data))
    else $error("taken bit not output");
  AST_OUT_HOLD: assert property (!take |=> $stable(o_data_out))
    else $error("output bit moved");
  AST_ONE_PER_TICK: assert property (o_bit_valid |=> !o_bit_valid [*8])
    else $error("bits too close");
  AST_LOCK_THR: assert property (o_lock |-> o_raw_err < 16'h0010)
    else $error("lock above threshold");
  AST_LOCK_UPD: assert property ($changed(o_lock) |-> $past(win_end))
    else $error("lock moved off window end");
  AST_RAW_WINDOW: assert property ($changed(o_raw_err) |=> $stable(o_raw_err) [*8])
    else $error("raw count not per window");
  AST_RAW_AT_END: assert property (!$past(win_end) |-> $stable(o_raw_err))
    else $error("raw count moved inside window");
  AST_FULL_BY_WRITE: assert property ($fell(o_sym_ready) |-> $past(i_sym_valid))
    else $error("store full without write");
endmodule
bind sfd_decoder sfd_decoder_chk u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
  .i_sym_valid(i_sym_valid), .o_sym_ready(o_sym_ready), .o_bit_valid(o_bit_valid),
  .o_bit_data(o_bit_data), .i_bit_ready(i_bit_ready), .o_data_clk(o_data_clk),
  .o_data_out(o_data_out), .o_lock(o_lock), .o_raw_err(o_raw_err));

// ---- tb/sfd_demod_model.sv ----
// Demodulator model: offers strong soft symbols of the all-zero codeword.
`timescale 1ns/1ps
module sfd_demod_model (
  input  wire       i_sys_clk,  // System clock.
  input  wire       i_srst,     // Synchronous reset.
  input  wire       i_en,       // Offer symbols.
  input  wire [1:0] i_rot,      // Phase rotation seen by the decoder.
  input  wire       i_ready,    // Decoder takes the symbol.
  output reg        o_valid,    // Symbol offered.
  output reg  [1:0] o_sym_i,    // I soft value.
  output reg  [1:0] o_sym_q     // Q soft value.
);
  // Pre-rotated so that the decoder's corrector restores zeros.
  wire [1:0] pat_i = (i_rot == 2'h2 || i_rot == 2'h3) ? 2'h3 : 2'h0;
  wire [1:0] pat_q = (i_rot == 2'h1 || i_rot == 2'h2) ? 2'h3 : 2'h0;
  reg        gap_q;
  wire       offer = i_en && !gap_q;
  initial begin
    o_valid = 1'b0;
    o_sym_i = 2'h3;
    o_sym_q = 2'h3;
  end
  // An offered word holds until taken; idle lines show its inverse.
  always @(posedge i_sys_clk) begin
    gap_q <= ($urandom % 4 == 0);
    if (i_srst) begin
      o_valid <= 1'b0;
    end else if (!o_valid || i_ready) begin
      o_valid <= offer;
      o_sym_i <= offer ? pat_i : ~pat_i;
      o_sym_q <= offer ? pat_q : ~pat_q;
    end
  end
endmodule

// ---- tb/sequential_fec_decoder_tb.sv ----
// Self-checking bench for the sequential decoder.
`timescale 1ns/1ps
module sequential_fec_decoder_tb;
  reg         i_sys_clk = 1'b0;
  reg         i_srst    = 1'b1;
  reg         i_bit_ready = 1'b0;
  reg  [1:0]  i_amb_rot = 2'h0;
  reg         en = 1'b0;
  reg         stall = 1'b0;
  wire        sym_valid, o_sym_ready, o_bit_valid, o_bit_data;
  wire        o_data_clk, o_data_out, o_lock;
  wire [1:0]  sym_i, sym_q;
  wire [15:0] o_raw_err;
  integer     fails = 0, n_compared = 0, n_acc = 0, cyc = 0, k, w, r;
  reg         exp_q[$];
  always #20 i_sys_clk = ~i_sys_clk;
  sfd_demod_model u_src (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_en(en), .i_rot(i_amb_rot),
    .i_ready(o_sym_ready), .o_valid(sym_valid), .o_sym_i(sym_i), .o_sym_q(sym_q));
  sfd_decoder u_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_sym_valid(sym_valid),
    .i_sym_i(sym_i), .i_sym_q(sym_q), .o_sym_ready(o_sym_ready), .i_amb_rot(i_amb_rot),
    .o_bit_valid(o_bit_valid), .o_bit_data(o_bit_data), .i_bit_ready(i_bit_ready),
    .o_data_clk(o_data_clk), .o_data_out(o_data_out), .o_lock(o_lock), .o_raw_err(o_raw_err));
  task chk(input bit ok, input string m);
    n_compared = n_compared + 1;
    if (!ok) begin
      fails = fails + 1;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task test_done;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Driver notes and output monitor
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    i_bit_ready <= !stall && ($urandom % 8 != 0);
    if (i_srst) begin
      exp_q.delete();
      n_acc <= 0;
    end else if (sym_valid && o_sym_ready) begin
      exp_q.push_back(1'b0);
      n_acc <= n_acc + 1;
    end
    if (cyc > 90000) begin
      fails = fails + 1;
      test_done;
    end
  end
  // Every symbol of the zero codeword must come out as a zero, in order.
  always @(posedge i_sys_clk) begin
    if (!i_srst && o_bit_valid && i_bit_ready) begin
      if (exp_q.size() == 0) chk(1'b0, "bit with no symbol");
      else chk(o_bit_data === exp_q.pop_front(), "wrong corrected bit");
    end
  end
  task restart(input [1:0] rot);
    @(posedge i_sys_clk);
    i_srst <= 1'b1;
    i_amb_rot <= rot;
    repeat (4) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    en <= 1'b1;
  endtask
  task wait_acc(input integer n, input integer lim);
    w = 0;
    while (n_acc < n && w < lim) begin
      @(posedge i_sys_clk);
      #1 w = w + 1;
    end
    chk(n_acc >= n, "symbols not taken");
    @(posedge i_sys_clk);
    en <= 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    r = $urandom(32'h3662);
    repeat (4) @(posedge i_sys_clk);
    for (k = 0; k < 4; k = k + 1) begin
      stall <= (k == 0);
      restart(k[1:0]);
      if (k == 0) begin
        w = 0;
        while (o_sym_ready !== 1'b0 && w < 3000) begin
          @(posedge i_sys_clk);
          #1 w = w + 1;
        end
        chk(o_sym_ready === 1'b0 && n_acc >= 63, "store never refused");
        @(posedge i_sys_clk);
        stall <= 1'b0;
      end
      wait_acc(48, 4000);
      w = 0;
      while (exp_q.size() > 2 && w < 6000) begin
        @(posedge i_sys_clk);
        #1 w = w + 1;
      end
      chk(exp_q.size() <= 2, "bits held back");
    end
    restart(2'h0);
    wait_acc(1100, 60000);
    w = 0;
    while (o_lock !== 1'b1 && w < 8000) begin
      @(posedge i_sys_clk);
      #1 w = w + 1;
    end
    chk(o_lock === 1'b1, "no lock on clean data");
    chk(o_raw_err === 16'h0000, "raw count on clean data");
    chk(o_data_out === 1'b0, "retimed bit not zero");
    test_done;
  end
endmodule
